// *** rtl/idf_pkg.sv ***
package idf_pkg;
  // register indices, byte offset is index*4 (printed offsets are not all multiples of four)
  localparam logic [7:0] IDX_ADDR_LOW    = 8'h08;
  localparam logic [7:0] IDX_ADDR_CTRL   = 8'h09;
  localparam logic [7:0] IDX_BW_USAGE    = 8'h15;
  localparam logic [7:0] IDX_IDENTIFIER  = 8'h16;
  localparam logic [7:0] IDX_REVISION    = 8'h1F;
  localparam logic [7:0] IDX_READ_BUFFER = 8'h88;
  localparam logic [7:0] IDX_MEM_DATA    = 8'hC0;
  localparam logic [7:0] IDX_FLOW_CTRL   = 8'h30;
  localparam logic [7:0] IDX_FLOW_STATUS = 8'h31;
  // control register fields
  localparam int CTRL_ADDR_HI_LSB = 0;
  localparam int CTRL_CLEAR_BIT   = 6;
  localparam int CTRL_INC_BIT     = 7;
  // flow control fields
  localparam int FLOW_MODE_LSB    = 0;
  localparam int FLOW_RATE_LSB    = 2;
  localparam int FLOW_SLAVE_BIT   = 4;
  // reset values and limits
  localparam logic [11:0] ADDR_RESET     = 12'h000;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [7:0]  BW_FULL_SCALE  = 8'h7C;
  localparam logic [6:0]  MAX_SLOT_INDEX = 7'h7F;
  // frame timing: 125 us at 50 MHz
  localparam int FRAME_NS     = 125000;
  localparam int CLK_NS       = 20;
  localparam int FRAME_CYCLES = FRAME_NS / CLK_NS;
  // bandwidth window length
  localparam int BW_WINDOW    = 124;
  // rate codes selecting the slot count
  typedef enum logic [1:0] {RATE_LOW, RATE_MID, RATE_HIGH, RATE_SHORT} idf_rate_type;
endpackage

// *** rtl/idf_data_flow.sv ***
`timescale 1ns/10ps
`default_nettype none
module idf_data_flow #(
  parameter int          FRAME_LEN   = idf_pkg::FRAME_CYCLES, // cycles per 125 us frame
  parameter int          FIFO_COUNT  = 16,                    // FIFOs per direction
  parameter logic [7:0]  ID_VALUE    = 8'h5A,                 // arbitrary identifier value
  parameter logic [3:0]  REV_VALUE   = 4'h1,                  // arbitrary revision value
  parameter logic [6:0]  SLAVE_LAST  = 7'h7F                  // last slot index in slave mode
) (
  input  wire logic        clk,          // 50 MHz system clock
  input  wire logic        rstn,         // async reset, active low
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb enable
  input  wire logic        pwrite,       // apb direction
  input  wire logic [11:0] paddr,        // apb byte address
  input  wire logic [31:0] pwdata,       // apb write data
  output logic      [31:0] prdata,       // apb read data
  output logic             pready,       // apb ready
  output logic             pslverr,      // apb error on unmapped address
  input  wire logic [7:0]  lineRxByte,   // byte received from line, per slot
  input  wire logic [7:0]  pcmRxByte,    // byte received from pcm, per slot
  output logic      [7:0]  lineTxByte,   // byte sent to line
  output logic      [7:0]  pcmTxByte,    // byte sent to pcm
  output logic      [3:0]  channelNum,   // routing channel now served
  output logic      [6:0]  slotNum,      // pcm slot now served
  output logic             frameStart    // one-cycle frame pulse
);
  localparam int FW = $clog2(FRAME_LEN);

  // apb access decode
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a == {2'b00, idx, 2'b00});
  endfunction

  logic        setup;
  logic        access;
  logic [11:0] memAddr;
  logic        autoInc;
  logic [7:0]  memory [0:4095];
  logic [7:0]  readBuffer;
  logic [1:0]  flowMode;
  logic [1:0]  rateSel;
  logic        slaveMode;
  logic [FW-1:0] frameCount;
  logic [6:0]  slotLast;
  logic [6:0]  cfgLast;
  logic [6:0]  slotCount;
  logic [7:0]  busyWindow;
  logic [7:0]  busyCount;
  logic [7:0]  bandwidth;
  logic        memBusy;
  logic [7:0]  lineLatch;
  logic [7:0]  pcmLatch;
  logic [7:0]  lineSync1;
  logic [7:0]  lineSync2;
  logic [7:0]  pcmSync1;
  logic [7:0]  pcmSync2;
  logic        mapped;

  assign setup  = psel & ~penable;
  assign access = psel & penable & pready;
  assign mapped = hit(paddr, idf_pkg::IDX_ADDR_LOW) | hit(paddr, idf_pkg::IDX_ADDR_CTRL)
                | hit(paddr, idf_pkg::IDX_BW_USAGE) | hit(paddr, idf_pkg::IDX_IDENTIFIER)
                | hit(paddr, idf_pkg::IDX_REVISION) | hit(paddr, idf_pkg::IDX_READ_BUFFER)
                | hit(paddr, idf_pkg::IDX_MEM_DATA) | hit(paddr, idf_pkg::IDX_FLOW_CTRL)
                | hit(paddr, idf_pkg::IDX_FLOW_STATUS);

  // one wait state: ready in the second access cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pready <= 1'b0;
    else
      pready <= psel & penable & ~pready;
  end

  // address pointer: low byte, high nibble, clear and increment
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      memAddr <= idf_pkg::ADDR_RESET;
      autoInc <= 1'b0;
    end
    else if (access && pwrite && hit(paddr, idf_pkg::IDX_ADDR_LOW))
      memAddr[7:0] <= pwdata[7:0];
    else if (access && pwrite && hit(paddr, idf_pkg::IDX_ADDR_CTRL))
    begin
      autoInc <= pwdata[idf_pkg::CTRL_INC_BIT];
      if (pwdata[idf_pkg::CTRL_CLEAR_BIT])
        memAddr <= idf_pkg::ADDR_RESET; // clear bit is never stored
      else
        memAddr[11:8] <= pwdata[idf_pkg::CTRL_ADDR_HI_LSB +: 4];
    end
    else if (access && hit(paddr, idf_pkg::IDX_MEM_DATA) && autoInc)
      memAddr <= memAddr + 12'h001;
  end

  // memory port: write direct, read lands in the buffer
  always_ff @(posedge clk)
  begin
    if (access && pwrite && hit(paddr, idf_pkg::IDX_MEM_DATA))
      memory[memAddr] <= pwdata[7:0];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      readBuffer <= idf_pkg::REG_RESET;
    else if (access && !pwrite && hit(paddr, idf_pkg::IDX_MEM_DATA))
      readBuffer <= memory[memAddr]; // deferred read
  end

  // flow configuration register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flowMode  <= 2'b00;
      rateSel   <= 2'b00;
      slaveMode <= 1'b0;
    end
    else if (access && pwrite && hit(paddr, idf_pkg::IDX_FLOW_CTRL))
    begin
      if (pwdata[idf_pkg::FLOW_MODE_LSB +: 2] != 2'b11)
        flowMode <= pwdata[idf_pkg::FLOW_MODE_LSB +: 2];
      rateSel   <= pwdata[idf_pkg::FLOW_RATE_LSB +: 2];
      slaveMode <= pwdata[idf_pkg::FLOW_SLAVE_BIT];
    end
  end

  // last slot index from mode and rate
  always_comb
  begin
    if (slaveMode)
      cfgLast = SLAVE_LAST;
    else
    begin
      unique case (idf_pkg::idf_rate_type'(rateSel))
        idf_pkg::RATE_LOW:   cfgLast = 7'd31;
        idf_pkg::RATE_MID:   cfgLast = 7'd63;
        idf_pkg::RATE_HIGH:  cfgLast = idf_pkg::MAX_SLOT_INDEX;
        idf_pkg::RATE_SHORT: cfgLast = 7'd11;
      endcase
    end
  end

  // 125 us frame timer and frame start pulse
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      frameCount <= '0;
      frameStart <= 1'b0;
    end
    else
    begin
      frameStart <= (frameCount == FW'(FRAME_LEN - 1));
      if (frameCount == FW'(FRAME_LEN - 1))
        frameCount <= '0;
      else
        frameCount <= frameCount + FW'(1);
    end
  end

  // one byte per slot per frame; slot pace from frame counter low bits
  // last slot index latched at the boundary, so a mid-frame change cannot overrun
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      slotCount  <= 7'h00;
      channelNum <= 4'h0;
      slotNum    <= 7'h00;
      slotLast   <= 7'h1F;
    end
    else if (frameCount == FW'(FRAME_LEN - 1))
    begin
      slotLast   <= cfgLast;
      slotCount  <= 7'h00;
      channelNum <= 4'h0;
      slotNum    <= 7'h00;
    end
    else if (frameCount[4:0] == 5'h1F && slotCount != slotLast)
    begin
      slotCount  <= slotCount + 7'h01;
      slotNum    <= slotCount + 7'h01; // pcm domain
      channelNum <= 4'((slotCount + 7'h01) % 7'(FIFO_COUNT));
    end
  end

  // input synchronisers for pin bytes
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lineSync1 <= 8'h00;
      lineSync2 <= 8'h00;
      pcmSync1  <= 8'h00;
      pcmSync2  <= 8'h00;
    end
    else
    begin
      lineSync1 <= lineRxByte;
      lineSync2 <= lineSync1;
      pcmSync1  <= pcmRxByte;
      pcmSync2  <= pcmSync1;
    end
  end

  // routing: fifo memory slot, line and pcm switching per mode
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lineLatch  <= 8'h00;
      pcmLatch   <= 8'h00;
      lineTxByte <= 8'h00;
      pcmTxByte  <= 8'h00;
    end
    else if (frameCount[4:0] == 5'h00)
    begin
      lineLatch <= lineSync2;
      pcmLatch  <= pcmSync2;
      unique case (flowMode)
        2'b00:
        begin
          lineTxByte <= memory[{8'h00, channelNum}]; // fifo to line, fixed map
          pcmTxByte  <= memory[{8'h00, channelNum}]; // fifo to pcm
        end
        2'b01:
        begin
          lineTxByte <= pcmLatch;  // pcm to line
          pcmTxByte  <= lineLatch; // line to pcm
        end
        default:
        begin
          lineTxByte <= lineLatch;
          pcmTxByte  <= {pcmLatch[7:4], lineLatch[3:0]}; // nibble subchannel merge
        end
      endcase
    end
  end

  // memory busy: any host data access or slot fetch
  assign memBusy = (access && hit(paddr, idf_pkg::IDX_MEM_DATA)) || frameCount[4:0] == 5'h00;

  // bandwidth usage over fixed window, full scale when always busy
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busyWindow <= 8'h00;
      busyCount  <= 8'h00;
      bandwidth  <= 8'h00;
    end
    else if (busyWindow == 8'(idf_pkg::BW_WINDOW - 1))
    begin
      busyWindow <= 8'h00;
      busyCount  <= 8'h00;
      bandwidth  <= busyCount + {7'h00, memBusy};
    end
    else
    begin
      busyWindow <= busyWindow + 8'h01;
      busyCount  <= busyCount + {7'h00, memBusy};
    end
  end

  // apb read data and error
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      pslverr <= ~mapped;
      prdata  <= 32'h0000_0000;
      if (!pwrite)
      begin
        if (hit(paddr, idf_pkg::IDX_BW_USAGE))
          prdata[7:0] <= bandwidth;
        else if (hit(paddr, idf_pkg::IDX_IDENTIFIER))
          prdata[7:0] <= ID_VALUE;
        else if (hit(paddr, idf_pkg::IDX_REVISION))
          prdata[7:0] <= {4'h0, REV_VALUE};
        else if (hit(paddr, idf_pkg::IDX_READ_BUFFER))
          prdata[7:0] <= readBuffer;
        else if (hit(paddr, idf_pkg::IDX_FLOW_CTRL))
          prdata[7:0] <= {3'b000, slaveMode, rateSel, flowMode};
        else if (hit(paddr, idf_pkg::IDX_FLOW_STATUS))
          prdata[7:0] <= {1'b0, slotNum};
        else if (hit(paddr, idf_pkg::IDX_ADDR_CTRL))
          prdata[7:0] <= {autoInc, 3'b000, memAddr[11:8]};
      end
    end
    else
    begin
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // assertions
  AST_READY_ONE_WAIT: assert property (@(posedge clk) disable iff (!rstn)
    (setup ##1 (psel && penable)) |=> pready)
    else $error("ready not after one wait");
  AST_ADDR_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
    (access && pwrite && hit(paddr, idf_pkg::IDX_ADDR_CTRL) && pwdata[6]) |=> memAddr == 12'h000)
    else $error("address not cleared");
  AST_ADDR_LOW: assert property (@(posedge clk) disable iff (!rstn)
    (access && pwrite && hit(paddr, idf_pkg::IDX_ADDR_LOW)) |=> memAddr[7:0] == $past(pwdata[7:0]))
    else $error("low address not loaded");
  AST_AUTO_INC: assert property (@(posedge clk) disable iff (!rstn)
    (access && hit(paddr, idf_pkg::IDX_MEM_DATA) && autoInc) |=> memAddr == $past(memAddr) + 12'h001)
    else $error("address did not advance");
  AST_NO_INC: assert property (@(posedge clk) disable iff (!rstn)
    (access && hit(paddr, idf_pkg::IDX_MEM_DATA) && !autoInc) |=> $stable(memAddr))
    else $error("address moved without increment");
  AST_BUFFER: assert property (@(posedge clk) disable iff (!rstn)
    (access && !pwrite && hit(paddr, idf_pkg::IDX_MEM_DATA)) |=> readBuffer == $past(memory[memAddr]))
    else $error("buffer not loaded");
  AST_BW_RANGE: assert property (@(posedge clk) disable iff (!rstn)
    bandwidth <= idf_pkg::BW_FULL_SCALE)
    else $error("bandwidth above full scale");
  AST_SLOT_RANGE: assert property (@(posedge clk) disable iff (!rstn)
    slotCount <= slotLast || $changed(slotLast))
    else $error("slot beyond frame");
  AST_FRAME: assert property (@(posedge clk) disable iff (!rstn)
    frameStart |=> slotNum == 7'h00 && channelNum == 4'h0)
    else $error("frame did not restart slots");
  AST_CHANNEL: assert property (@(posedge clk) disable iff (!rstn)
    channelNum < 4'(FIFO_COUNT) || FIFO_COUNT == 16)
    else $error("channel above fifo count");
  AST_READY_PULSE: assert property (@(posedge clk) disable iff (!rstn)
    pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_SLOT_STEP: assert property (@(posedge clk) disable iff (!rstn)
    (frameCount[4:0] != 5'h1F && frameCount != FW'(FRAME_LEN - 1)) |=> $stable(slotNum))
    else $error("slot moved off its step");
  AST_TX_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    (frameCount[4:0] != 5'h00) |=> ($stable(lineTxByte) && $stable(pcmTxByte)))
    else $error("transmit byte changed inside slot");
  AST_MODE_LEGAL: assert property (@(posedge clk) disable iff (!rstn)
    flowMode != 2'b11)
    else $error("illegal flow mode stored");
endmodule
`default_nettype wire

// *** verification/idf_line_pcm_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module idf_line_pcm_model (
  input  wire logic       clk,               // system clock
  input  wire logic       rstn,              // async reset, active low
  input  wire logic [6:0] slotNum,           // slot now served
  output logic      [7:0] lineRxByte = 8'h00, // byte from the line
  output logic      [7:0] pcmRxByte  = 8'h00  // byte from the pcm highway
);
  logic [6:0] lastSlot;

  // one whole fresh byte per served slot, changed right after the edge
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lastSlot   <= 7'h00;
      lineRxByte <= 8'h00;
      pcmRxByte  <= 8'h00;
    end
    else if (slotNum != lastSlot)
    begin
      lastSlot   <= slotNum;
      lineRxByte <= {1'b1, slotNum};
      pcmRxByte  <= ~{1'b0, slotNum};
    end
  end
endmodule
`default_nettype wire

// *** verification/idf_data_flow_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module idf_data_flow_tb;
  localparam int         FLEN = 4200;
  localparam logic [7:0] IDV  = 8'h5A; // arbitrary identifier value
  logic        clk        = 1'b0;
  logic        rstn       = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [11:0] paddr      = 12'h000;
  logic [31:0] pwdata     = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        frameStart;
  logic        err;
  logic [7:0]  lineRxByte;
  logic [7:0]  pcmRxByte;
  logic [7:0]  lineTxByte;
  logic [7:0]  pcmTxByte;
  logic [3:0]  channelNum;
  logic [3:0]  chRun      = 4'h0;
  logic [3:0]  chMax      = 4'h0;
  logic [6:0]  slotNum;
  logic [6:0]  slotRun    = 7'h00;
  logic [6:0]  slotMax    = 7'h00;
  logic [31:0] cfg [5]    = '{32'h00, 32'h05, 32'h0A, 32'h0C, 32'h10};
  logic [31:0] lastIdx [5] = '{32'h1F, 32'h3F, 32'h7F, 32'h0B, 32'h09};
  logic [31:0] lastCh [5]  = '{32'h0F, 32'h0F, 32'h0F, 32'h0B, 32'h09};
  // {line, pcm} at frame start: fifo byte, or the last slot's line/pcm bytes
  logic [15:0] txExp [5]   = '{16'h4040, 16'hC0BF, 16'hFF8F, 16'h4040, 16'h4040};
  int          mismatches = 0;
  int          numChecks  = 0;
  int          periodCnt  = 0;
  int          period     = 0;

  idf_data_flow #(.FRAME_LEN(FLEN), .FIFO_COUNT(16), .ID_VALUE(IDV), .REV_VALUE(4'h1),
    .SLAVE_LAST(7'h09)) i_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lineRxByte(lineRxByte), .pcmRxByte(pcmRxByte),
    .lineTxByte(lineTxByte), .pcmTxByte(pcmTxByte), .channelNum(channelNum),
    .slotNum(slotNum), .frameStart(frameStart));

  idf_line_pcm_model i_far (.clk(clk), .rstn(rstn), .slotNum(slotNum),
    .lineRxByte(lineRxByte), .pcmRxByte(pcmRxByte));

  // clock
  always #10 clk = ~clk;

  // frame length and highest slot and channel seen per frame
  always @(posedge clk)
  begin
    periodCnt <= frameStart ? 1 : periodCnt + 1;
    if (frameStart)
    begin
      period  <= periodCnt;
      slotMax <= slotRun;
      chMax   <= chRun;
      slotRun <= slotNum;
      chRun   <= channelNum;
    end
    else
    begin
      if (slotNum > slotRun)
        slotRun <= slotNum;
      if (channelNum > chRun)
        chRun <= channelNum;
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // one apb transfer; answer taken at the edge that samples pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      check("apb ready", 32'h1, 32'h0);
  endtask

  task automatic read_check(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask

  task automatic wait_frame;
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (frameStart !== 1'b1 && n < 2 * FLEN);
    @(negedge clk); // let the frame monitor take the pulse
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #(20 * 100000);
    mismatches++;
    complete_run();
  end

  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    check("reset prdata", 32'h0, prdata);
    rstn <= 1'b1;
    read_check("identifier", 12'h058, {24'h0, IDV});
    apb(1'b1, 12'h058, 32'hFF);
    read_check("identifier kept", 12'h058, {24'h0, IDV});
    apb(1'b0, 12'h07C, 32'h0);
    check("revision", 32'h1, rd & 32'h0000000F);
    apb(1'b1, 12'h054, 32'hFF);
    apb(1'b0, 12'h054, 32'h0);
    check("usage range", 32'h1, {31'h0, rd <= idf_pkg::BW_FULL_SCALE});
    apb(1'b0, 12'h3FC, 32'h0);
    check("unmapped error", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    // address setup, auto increment, clear
    apb(1'b1, 12'h024, 32'h83);
    read_check("ctrl", 12'h024, 32'h83);
    apb(1'b1, 12'h024, 32'hC0);
    read_check("ctrl cleared", 12'h024, 32'h80);
    apb(1'b1, 12'h020, 32'h05);
    for (int i = 0; i < 4; i++)
      apb(1'b1, 12'h300, 32'hA0 + 32'(i));
    apb(1'b1, 12'h024, 32'hC0);
    apb(1'b1, 12'h020, 32'h05);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 12'h300, 32'h0);
      check("port read", 32'h0, rd);
      read_check("deferred", 12'h220, 32'hA0 + 32'(i));
    end
    apb(1'b1, 12'h024, 32'h40);
    apb(1'b1, 12'h300, 32'h40);
    // each rate, mode and slave frame
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, 12'h0C0, cfg[i]);
      repeat (3) wait_frame();
      check("last slot", lastIdx[i], {25'h0, slotMax});
      check("last channel", lastCh[i], {28'h0, chMax});
      check("frame length", 32'(FLEN), 32'(period));
      check("route", {16'h0, txExp[i]}, {16'h0, lineTxByte, pcmTxByte});
      apb(1'b0, 12'h0C4, 32'h0);
      check("slot status", 32'h1, {31'h0, rd <= lastIdx[i]});
    end
    apb(1'b0, 12'h054, 32'h0);
    check("usage busy", 32'h1, {31'h0, rd <= idf_pkg::BW_FULL_SCALE});
    complete_run();
  end
endmodule
`default_nettype wire
